// *** logic/srcp_pkg.sv ***
package srcp_pkg;
  // Clock rate and selectable line rates
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned BAUD_MIN = 9600;
  localparam int unsigned BAUD_MAX = 115200;
  localparam int unsigned DIV_MAX = CLK_HZ / BAUD_MIN;
  localparam int unsigned DIV_MIN = CLK_HZ / BAUD_MAX;
  localparam int DIV_W = 14;
  localparam logic [DIV_W-1:0] DIV_RST = 14'(CLK_HZ / BAUD_MIN);
  // Frame layout
  localparam int DATA_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // Handshake and terminator characters
  localparam logic [7:0] CH_REQ = 8'hAA;
  localparam logic [7:0] CH_GRANT = 8'hCC;
  localparam logic [7:0] CH_END = 8'h0A;
  // Command buffer
  localparam int CMD_DEPTH = 64;
  localparam int CMD_AW = 6;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } srcp_byte_t;

  typedef enum {
    SRCP_WAIT_REQ,
    SRCP_SEND_GRANT,
    SRCP_COLLECT,
    SRCP_DELIVER
  } srcp_cmd_st_t;
endpackage

// *** logic/srcp_port.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Bit period set by baud divisor input, 9600 to 115200 baud range.
// - Frames are one start, eight data, no parity, one stop.
// - Request answered by grant 0xCC; host waits for it before the command.
// - Responses are sent straight away, no request or grant involved.
// - Every response string ends with a line feed, code 10.
module srcp_port (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [13:0] baud_div,
  input wire logic rxd,
  output logic txd,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  output logic rsp_ready,
  output logic [7:0] cmd_data,
  output logic cmd_valid,
  output logic cmd_last,
  input wire logic cmd_ready,
  output logic cmd_overflow
);
  // Divisor clamped to the legal range so a bad setting cannot stall the line
  logic [13:0] div_w;
  assign div_w = (baud_div < 14'(srcp_pkg::DIV_MIN)) ? 14'(srcp_pkg::DIV_MIN) :
                 (baud_div > 14'(srcp_pkg::DIV_MAX)) ? 14'(srcp_pkg::DIV_MAX) : baud_div;

  // Three-stage synchroniser; only stages two and three are compared
  logic [2:0] rx_sync_r;
  logic rx_r;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_sync_r <= 3'h7;
      rx_r <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], rxd};
      if (rx_sync_r[1] == rx_sync_r[2]) rx_r <= rx_sync_r[2];
    end
  end

  // Receiver: half period to mid start bit, then full periods
  logic rx_busy_r;
  logic [13:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_stb_r;
  logic [7:0] rx_byte_r;
  logic rx_tick;
  assign rx_tick = (rx_cnt_r == 14'h0000);
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 14'h0000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_stb_r <= 1'b0;
      rx_byte_r <= 8'h00;
    end else begin
      rx_stb_r <= 1'b0;
      if (!rx_busy_r) begin
        if (!rx_r) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= {1'b0, div_w[13:1]};
          rx_bit_r <= 4'hF;
        end
      end else if (!rx_tick) begin
        rx_cnt_r <= rx_cnt_r - 14'h0001;
      end else begin
        rx_cnt_r <= div_w - 14'h0001;
        if (rx_bit_r == 4'hF) begin
          if (rx_r) rx_busy_r <= 1'b0; // False start rejected
          rx_bit_r <= 4'h0;
        end else if (rx_bit_r <= srcp_pkg::LAST_BIT) begin
          rx_sh_r <= {rx_r, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 4'h1;
        end else begin
          rx_busy_r <= 1'b0;
          // Framing error drops the character
          if (rx_r) begin
            rx_stb_r <= 1'b1;
            rx_byte_r <= rx_sh_r;
          end
        end
      end
    end
  end

  // Command handshake and buffering
  srcp_pkg::srcp_cmd_st_t st_r;
  logic [7:0] buf_r [0:srcp_pkg::CMD_DEPTH-1];
  logic [5:0] wr_ptr_r, rd_ptr_r, end_ptr_r;
  logic grant_req_r, grant_taken, ovf_r, skid_full;
  logic req_seen;
  assign req_seen = (st_r == srcp_pkg::SRCP_WAIT_REQ) && rx_stb_r && (rx_byte_r == srcp_pkg::CH_REQ);
  logic [5:0] rd_nxt;
  assign rd_nxt = rd_ptr_r + 6'h01;
  logic push_ok;
  assign push_ok = (st_r == srcp_pkg::SRCP_COLLECT) && rx_stb_r;
  always_ff @(posedge clk_sys) begin
    if (push_ok) buf_r[wr_ptr_r] <= rx_byte_r;
  end
  logic cmd_pop;
  assign cmd_pop = (st_r == srcp_pkg::SRCP_DELIVER) && !skid_full;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_r <= srcp_pkg::SRCP_WAIT_REQ;
      wr_ptr_r <= 6'h00;
      rd_ptr_r <= 6'h00;
      end_ptr_r <= 6'h00;
      grant_req_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      case (st_r)
        srcp_pkg::SRCP_WAIT_REQ: begin
          // Anything but the request byte is ignored here
          if (req_seen) begin
            st_r <= srcp_pkg::SRCP_SEND_GRANT;
            grant_req_r <= 1'b1;
          end
        end
        srcp_pkg::SRCP_SEND_GRANT: begin
          if (grant_taken) begin
            grant_req_r <= 1'b0;
            st_r <= srcp_pkg::SRCP_COLLECT;
            wr_ptr_r <= 6'h00;
            ovf_r <= 1'b0;
          end
        end
        srcp_pkg::SRCP_COLLECT: begin
          if (rx_stb_r) begin
            if (rx_byte_r == srcp_pkg::CH_END) begin
              st_r <= srcp_pkg::SRCP_DELIVER;
              end_ptr_r <= wr_ptr_r;
              rd_ptr_r <= 6'h00;
            end else if (wr_ptr_r == 6'(srcp_pkg::CMD_DEPTH - 1)) begin
              ovf_r <= 1'b1; // Long strings are cut; the tail is lost
            end else begin
              wr_ptr_r <= wr_ptr_r + 6'h01;
            end
          end
        end
        srcp_pkg::SRCP_DELIVER: begin
          if (cmd_pop) begin
            rd_ptr_r <= rd_nxt;
            if (rd_ptr_r == end_ptr_r) st_r <= srcp_pkg::SRCP_WAIT_REQ;
          end
        end
        default: st_r <= srcp_pkg::SRCP_WAIT_REQ;
      endcase
    end
  end

  // Two-entry skid buffer toward the interpreter, so a stall loses no word
  srcp_pkg::srcp_byte_t sk0_r, sk1_r;
  logic sk_last0_r, sk_last1_r;
  assign skid_full = sk1_r.valid;
  logic pop_out;
  assign pop_out = sk0_r.valid && cmd_ready;
  logic [7:0] pop_byte;
  assign pop_byte = buf_r[rd_ptr_r];
  logic pop_last;
  assign pop_last = (rd_ptr_r == end_ptr_r);
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sk0_r <= '0;
      sk1_r <= '0;
      sk_last0_r <= 1'b0;
      sk_last1_r <= 1'b0;
    end else begin
      if (pop_out || !sk0_r.valid) begin
        if (sk1_r.valid) begin
          sk0_r <= sk1_r;
          sk_last0_r <= sk_last1_r;
          sk1_r.valid <= cmd_pop;
          sk1_r.data <= pop_byte;
          sk_last1_r <= pop_last;
        end else begin
          sk0_r.valid <= cmd_pop;
          sk0_r.data <= pop_byte;
          sk_last0_r <= pop_last;
        end
      end else if (cmd_pop) begin
        sk1_r.valid <= 1'b1;
        sk1_r.data <= pop_byte;
        sk_last1_r <= pop_last;
      end
    end
  end

  // Transmitter: grant has priority, responses are sent with no handshake
  logic tx_busy_r;
  logic [13:0] tx_cnt_r;
  logic [3:0] tx_bit_r;
  logic [9:0] tx_sh_r;
  logic lf_pend_r;
  logic rsp_rdy_r;
  logic tx_idle;
  assign tx_idle = !tx_busy_r;
  assign grant_taken = tx_idle && grant_req_r;
  logic rsp_take;
  assign rsp_take = tx_idle && !grant_req_r && !lf_pend_r && rsp_valid && rsp_rdy_r;
  logic lf_take;
  assign lf_take = tx_idle && !grant_req_r && lf_pend_r;
  logic [7:0] tx_load;
  assign tx_load = grant_req_r ? srcp_pkg::CH_GRANT : lf_pend_r ? srcp_pkg::CH_END : rsp_data;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 14'h0000;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 10'h3FF;
      lf_pend_r <= 1'b0;
      rsp_rdy_r <= 1'b0;
      txd <= 1'b1;
    end else begin
      txd <= tx_sh_r[0];
      // A request seen now claims the line next, so ready must not promise a slot
      rsp_rdy_r <= !tx_busy_r && !grant_req_r && !lf_pend_r && !rsp_take && !req_seen;
      if (rsp_take) lf_pend_r <= rsp_last;
      else if (lf_take) lf_pend_r <= 1'b0;
      if (grant_taken || rsp_take || lf_take) begin
        tx_busy_r <= 1'b1;
        tx_sh_r <= {1'b1, tx_load, 1'b0};
        tx_cnt_r <= div_w - 14'h0001;
        tx_bit_r <= 4'h0;
      end else if (tx_busy_r) begin
        if (tx_cnt_r != 14'h0000) begin
          tx_cnt_r <= tx_cnt_r - 14'h0001;
        end else begin
          tx_cnt_r <= div_w - 14'h0001;
          tx_sh_r <= {1'b1, tx_sh_r[9:1]};
          tx_bit_r <= tx_bit_r + 4'h1;
          if (tx_bit_r == 4'(srcp_pkg::DATA_BITS + 1)) tx_busy_r <= 1'b0;
        end
      end
    end
  end

  // Outputs are flops of the stages above
  assign rsp_ready = rsp_rdy_r;
  assign cmd_data = sk0_r.data;
  assign cmd_valid = sk0_r.valid;
  assign cmd_last = sk_last0_r;
  assign cmd_overflow = ovf_r;

  property p_grant_after_req;
    @(posedge clk_sys) disable iff (!resetn)
      (req_seen && tx_idle && !rsp_take && !lf_take) |=> grant_taken && tx_load == srcp_pkg::CH_GRANT;
  endproperty
  a_grant_after_req: assert property (p_grant_after_req) else $error("grant not sent after request");
  property p_end_delivers;
    @(posedge clk_sys) disable iff (!resetn)
      (st_r == srcp_pkg::SRCP_COLLECT && rx_stb_r && rx_byte_r == srcp_pkg::CH_END)
      |=> st_r == srcp_pkg::SRCP_DELIVER;
  endproperty
  a_end_delivers: assert property (p_end_delivers) else $error("end byte did not start delivery");
  property p_no_collect_before_grant;
    @(posedge clk_sys) disable iff (!resetn)
      (st_r == srcp_pkg::SRCP_WAIT_REQ && rx_stb_r && rx_byte_r != srcp_pkg::CH_REQ)
      |=> st_r == srcp_pkg::SRCP_WAIT_REQ && !grant_req_r;
  endproperty
  a_no_collect_before_grant: assert property (p_no_collect_before_grant) else $error("byte stored before grant");
  property p_lf_after_last;
    @(posedge clk_sys) disable iff (!resetn)
      (rsp_take && rsp_last) |=> lf_pend_r;
  endproperty
  a_lf_after_last: assert property (p_lf_after_last) else $error("terminator not queued");
  property p_start_bit;
    @(posedge clk_sys) disable iff (!resetn)
      (tx_idle && (grant_taken || rsp_take || lf_take)) |=> ##1 !txd;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit missing");
  property p_direct_send;
    @(posedge clk_sys) disable iff (!resetn)
      (rsp_valid && rsp_ready) |-> rsp_take ##1 tx_busy_r;
  endproperty
  a_direct_send: assert property (p_direct_send) else $error("response not sent at once");
  property p_div_range;
    @(posedge clk_sys) disable iff (!resetn)
      div_w >= 14'(srcp_pkg::DIV_MIN) && div_w <= 14'(srcp_pkg::DIV_MAX);
  endproperty
  a_div_range: assert property (p_div_range) else $error("divisor out of range");
  property p_deliver_ends;
    @(posedge clk_sys) disable iff (!resetn)
      (cmd_pop && rd_ptr_r == end_ptr_r) |=> st_r == srcp_pkg::SRCP_WAIT_REQ;
  endproperty
  a_deliver_ends: assert property (p_deliver_ends) else $error("no return to request wait");
  property p_idle_high;
    @(posedge clk_sys) disable iff (!resetn)
      (tx_idle && $past(tx_idle) && $past(tx_idle, 2)) |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
endmodule

// *** test/srcp_host.sv ***
`timescale 1ns/1ps
// Behavioural host computer on the far side of the serial line
module srcp_host #(
  parameter int DIV = 1085
) (
  input wire logic clk_sys,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] rx_q[$];
  int stop_errs = 0;

  // Line rests high between frames, as an idle UART line does
  initial rxd = 1'b1;

  // One frame: start, eight data bits LSB first, stop; DIV cycles a bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      rxd <= f[i];
      repeat (DIV - 1) @(posedge clk_sys);
    end
  endtask

  // Request first, then wait a bounded time for the grant before any character
  task automatic send_cmd(input logic [7:0] chars[$], output bit granted);
    send_byte(8'hAA);
    granted = 1'b0;
    for (int n = 0; n < 14 * DIV && !granted; n++) begin
      @(posedge clk_sys);
      granted = (rx_q.size() > 0) && (rx_q[$] === 8'hCC);
    end
    if (granted) begin
      foreach (chars[i]) send_byte(chars[i]);
      send_byte(8'h0A);
    end
  endtask

  // Sample each bit at its middle so a small rate error does no harm
  initial forever begin : rx_loop
    logic [7:0] b;
    @(posedge clk_sys);
    if (txd === 1'b0) begin
      repeat (DIV / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge clk_sys);
        b[i] = txd;
      end
      repeat (DIV) @(posedge clk_sys);
      if (txd !== 1'b1) stop_errs++;
      rx_q.push_back(b);
    end
  end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
  localparam int DIVI = 1085;
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic [7:0] exp_b;
  } srcp_row_t;
  logic clk_sys, resetn, rxd, txd, rsp_valid, rsp_last, rsp_ready;
  logic cmd_valid, cmd_last, cmd_ready, cmd_overflow;
  logic [7:0] rsp_data, cmd_data, b;
  logic [13:0] baud_div;
  bit granted;
  int num_checks = 0;
  int miscompares = 0;
  srcp_row_t rows[2] = '{'{8'h41, 1'b0, 8'h41}, '{8'h42, 1'b1, 8'h42}};

  srcp_port DUT (.clk_sys(clk_sys), .resetn(resetn), .baud_div(baud_div), .rxd(rxd), .txd(txd),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
    .cmd_overflow(cmd_overflow));
  srcp_host #(.DIV(DIVI)) HOST (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Bounded wait for the next byte the host heard; X if none came
  task automatic wait_rx(output logic [7:0] r);
    int n;
    n = 0;
    while (HOST.rx_q.size() == 0 && n < 14 * DIVI) begin
      @(posedge clk_sys);
      n++;
    end
    r = (HOST.rx_q.size() > 0) ? HOST.rx_q.pop_front() : 8'hXX;
  endtask

  // Hold the response byte until an edge samples ready high, release on that edge
  task automatic send_rsp(input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(posedge clk_sys);
    rsp_valid <= 1'b1;
    rsp_data <= d;
    rsp_last <= l;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp_ready !== 1'b1 && n < 14 * DIVI);
    rsp_valid <= 1'b0;
  endtask

  initial begin
    resetn = 1'b0;
    baud_div = 14'h043D;
    rsp_valid = 1'b0;
    rsp_data = 8'h00;
    rsp_last = 1'b0;
    cmd_ready = 1'b0;
    repeat (12) @(posedge clk_sys);
    check({4'h0, txd, rsp_ready, cmd_valid, cmd_overflow}, 8'h08, "reset outputs");
    resetn <= 1'b1;
    $display("test reset done");
    // Responses leave at once, no request or grant needed
    foreach (rows[i]) begin
      send_rsp(rows[i].data, rows[i].last);
      wait_rx(b);
      check(b, rows[i].exp_b, "response byte");
    end
    wait_rx(b);
    check(b, 8'h0A, "line feed terminator");
    $display("test response done");
    // A stray byte while waiting must not be granted
    HOST.send_byte(8'h55);
    repeat (20) @(posedge clk_sys);
    check({7'h0, txd}, 8'h01, "no grant for stray byte");
    // Command collected while the receiver stalls, nothing lost
    HOST.send_cmd('{8'h58}, granted);
    check({7'h0, granted}, 8'h01, "grant seen");
    wait_rx(b);
    check(b, 8'hCC, "grant byte");
    repeat (100) @(posedge clk_sys);
    check({5'h0, cmd_valid, cmd_last, cmd_overflow}, 8'h04, "command flags");
    check(cmd_data, 8'h58, "command char");
    @(posedge clk_sys);
    cmd_ready <= 1'b1;
    @(posedge clk_sys);
    cmd_ready <= 1'b0;
    repeat (3) @(posedge clk_sys);
    // The end byte is handed over as the final word of the string
    check({6'h0, cmd_valid, cmd_last}, 8'h03, "end byte closes string");
    check(cmd_data, 8'h0A, "end byte value");
    cmd_ready <= 1'b1;
    @(posedge clk_sys);
    cmd_ready <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check({7'h0, cmd_valid}, 8'h00, "string fully handed over");
    check(8'(HOST.stop_errs), 8'h00, "stop bits");
    $display("test command done");
    // Reset in mid-frame: line returns to idle, ready drops, then comes back
    send_rsp(8'h33, 1'b0);
    repeat (50) @(posedge clk_sys);
    check({7'h0, txd}, 8'h00, "start bit on line");
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check({5'h0, txd, rsp_ready, cmd_valid}, 8'h04, "mid-run reset outputs");
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check({7'h0, rsp_ready}, 8'h01, "ready after reset");
    $display("test mid-run reset done");
    end_sim();
  end

  // Tests take some 90000 cycles at the smallest divisor
  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
